// *** bench/fmc_chunk_counters_properties.sv ***
`timescale 1ns/10ps
// Port-level checks of the metadata counters.
module fmc_props
(
	// Clocking and controls.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic metadata_mode_on,
	input wire logic frame_trigger_on,
	input wire logic count_clear_cmd,
	input wire logic [1:0] count_clear_src,
	input wire logic count_clear_src_wr,
	// Observed outputs.
	input wire logic frame_valid,
	input wire logic [63:0] frame_time_value,
	input wire logic frame_time_on,
	input wire logic [31:0] trigger_tally_value,
	input wire logic trigger_tally_on,
	input wire logic line_levels_on,
	input wire logic [63:0] time_now,
	input wire logic [31:0] tally_now,
	input wire logic [1:0] clear_src_now
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// A clear command counts only with the software source stored and the clock enabled.
	sequence s_soft_clear;
		clear_src_now == fmc_pkg::FMC_CLR_SOFT && count_clear_cmd && ce;
	endsequence
	a_time_step: assert property ($past(rst_n) && $past(ce) |->
		(time_now - $past(time_now)) inside {64'hc, 64'hd}) else $error("time step wrong");
	a_reset_clear: assert property ($rose(rst_n) |->
		time_now == 64'h0 && tally_now == 32'h0 && clear_src_now == 2'h0) else $error("reset state wrong");
	a_stamp_capture: assert property (frame_valid |->
		(time_now - frame_time_value) inside {64'hc, 64'hd}) else $error("stamp not from trigger");
	a_tally_capture: assert property (frame_valid |-> trigger_tally_value == tally_now)
		else $error("tally capture wrong");
	a_tally_inc: assert property (frame_valid |->
		tally_now == $past(tally_now) + 32'h1 || tally_now == 32'h1) else $error("tally step wrong");
	a_soft_clear: assert property (s_soft_clear |=> tally_now <= 32'h1)
		else $error("soft clear ignored");
	a_off_hold: assert property (!frame_trigger_on |=> tally_now <= $past(tally_now))
		else $error("counted while off");
	a_src_store: assert property (count_clear_src_wr && ce |=> clear_src_now == $past(count_clear_src))
		else $error("source not stored");
	a_mode_gate: assert property (!metadata_mode_on |=>
		!(frame_time_on || trigger_tally_on || line_levels_on)) else $error("attach while mode off");
	// A low clock enable must freeze the time stamp as well.
	a_ce_freeze: assert property (!ce |=> time_now == $past(time_now))
		else $error("time moved while frozen");
endmodule
bind fmc_chunk_counters fmc_props u_props (.clk, .rst_n, .ce, .metadata_mode_on, .frame_trigger_on,
	.count_clear_cmd, .count_clear_src, .count_clear_src_wr, .frame_valid, .frame_time_value, .frame_time_on,
	.trigger_tally_value, .trigger_tally_on, .line_levels_on, .time_now, .tally_now, .clear_src_now);

// *** bench/fmc_chunk_counters_tb.sv ***
`timescale 1ns/10ps
module fmc_chunk_counters_tb;
	logic clk, rst_n, ce, metadata_mode_on, metadata_kind_on, metadata_kind_wr, count_unit_pick, config_wr;
	logic count_clear_src_wr, count_clear_cmd, frame_trigger_on, acquire_trigger_pin, acquire_busy;
	logic frame_valid, frame_time_on, trigger_tally_on, line_levels_on;
	logic [1:0] metadata_kind_pick, count_unit_event_src, count_clear_src, in_line_pin, clear_src_now;
	logic [3:0] out_line_level;
	logic [63:0] frame_time_value, time_now, t0;
	logic [31:0] trigger_tally_value, line_levels_snapshot, tally_now;
	logic [7:0] frames;
	int errors = 0;
	int checked = 0;
	fmc_chunk_counters dut (.clk, .rst_n, .ce, .metadata_mode_on, .metadata_kind_pick, .metadata_kind_on,
		.metadata_kind_wr, .count_unit_pick, .count_unit_event_src, .config_wr, .count_clear_src,
		.count_clear_src_wr, .count_clear_cmd, .frame_trigger_on, .acquire_trigger_pin, .in_line_pin,
		.out_line_level, .acquire_busy, .frame_valid, .frame_time_value, .frame_time_on, .trigger_tally_value,
		.trigger_tally_on, .line_levels_snapshot, .line_levels_on, .time_now, .tally_now, .clear_src_now);
	fmc_host_model host (.clk, .rst_n, .frame_valid, .frames);
	// Clock at 100 ns.
	always #50 clk = ~clk;
	task step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(logic [63:0] seen, logic [63:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task kind(logic [1:0] k, logic on);
		metadata_kind_pick = k;
		metadata_kind_on = on;
		metadata_kind_wr = 1'b1;
		step(1);
		metadata_kind_wr = 1'b0;
	endtask
	task cfg(logic unit, logic [1:0] src);
		count_unit_pick = unit;
		count_unit_event_src = src;
		config_wr = 1'b1;
		step(1);
		config_wr = 1'b0;
	endtask
	task src(logic [1:0] s);
		count_clear_src = s;
		count_clear_src_wr = 1'b1;
		step(1);
		count_clear_src_wr = 1'b0;
		step(1);
	endtask
	// Pin held long enough to pass the synchroniser before release.
	task trig(logic busy);
		acquire_busy = busy;
		acquire_trigger_pin = 1'b1;
		step(6);
		acquire_trigger_pin = 1'b0;
		acquire_busy = 1'b0;
		step(2);
	endtask
	task complete_run;
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// The whole sequence needs about 110 cycles; this leaves ample margin.
	initial
	begin
		#100000;
		errors++;
		complete_run();
	end
	initial
	begin
		{clk, rst_n, metadata_mode_on, metadata_kind_on, metadata_kind_wr, count_unit_pick, config_wr} = '0;
		{count_clear_src_wr, count_clear_cmd, frame_trigger_on, acquire_trigger_pin, acquire_busy} = '0;
		{metadata_kind_pick, count_unit_event_src, count_clear_src, in_line_pin, out_line_level} = '0;
		ce = 1'b1;
		step(4);
		rst_n = 1'b1;
		chk({tally_now, 30'h0, clear_src_now}, 64'h0);
		t0 = time_now;
		step(10);
		chk(time_now - t0, 64'h7d);
		// Clock enable low freezes the stamp.
		ce = 1'b0;
		t0 = time_now;
		step(3);
		chk(time_now, t0);
		ce = 1'b1;
		metadata_mode_on = 1'b1;
		for (int k = 0; k < 3; k++)
			kind(2'(k), 1'b1);
		cfg(1'b0, fmc_pkg::FMC_EVT_TRIGGER);
		frame_trigger_on = 1'b1;
		in_line_pin = 2'h2;
		out_line_level = 4'h5;
		trig(1'b0);
		chk(trigger_tally_value, 64'h1);
		chk(line_levels_snapshot, 64'h502);
		chk({frame_time_on, trigger_tally_on, line_levels_on, frames}, 64'h701);
		trig(1'b1);
		chk({tally_now, frames}, 64'h201);
		trig(1'b0);
		chk(trigger_tally_value, 64'h3);
		frame_trigger_on = 1'b0;
		trig(1'b0);
		chk(tally_now, 64'h3);
		frame_trigger_on = 1'b1;
		count_clear_cmd = 1'b1;
		step(1);
		count_clear_cmd = 1'b0;
		chk(tally_now, 64'h3);
		src(fmc_pkg::FMC_CLR_SOFT);
		chk(clear_src_now, 64'h1);
		count_clear_cmd = 1'b1;
		step(1);
		count_clear_cmd = 1'b0;
		step(1);
		chk(tally_now, 64'h0);
		in_line_pin = 2'h0;
		for (int i = 0; i < 2; i++)
		begin
			src(2'(i + 2));
			trig(1'b0);
			in_line_pin[i] = 1'b1;
			step(5);
			chk(tally_now, 64'h0);
			in_line_pin[i] = 1'b0;
			step(2);
		end
		kind(2'h1, 1'b0);
		cfg(1'b1, fmc_pkg::FMC_EVT_OFF);
		trig(1'b0);
		chk({frame_time_on, trigger_tally_on}, 64'h2);
		metadata_mode_on = 1'b0;
		trig(1'b0);
		chk({frame_time_on, trigger_tally_on, line_levels_on}, 64'h0);
		complete_run();
	end
endmodule

// *** bench/fmc_host_model.sv ***
`timescale 1ns/10ps
// Host side: counts the frames that arrive with metadata.
module fmc_host_model
(
	// Clocking.
	input wire logic clk,
	input wire logic rst_n,
	// Frame strobe from the device.
	input wire logic frame_valid,
	output logic [7:0] frames
);
	// Each cycle with the strobe high is taken as one frame, so a strobe held while ce is low counts more than once.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			frames <= 8'h0;
		else if (frame_valid)
			frames <= frames + 8'h1;
	end
endmodule

// *** design/fmc_chunk_counters.sv ***
`timescale 1ns/10ps
// Behaviour
// - Time stamp is a 64-bit unsigned counter.
// - Time stamp advances one per 8 ns tick.
// - Time stamp restarts from zero at reset.
// - Enabled time stamp is captured at trigger and attached to that frame.
// - Clearing global mode disables every kind at once.
// - Host picks a kind then enables it; device attaches it each frame.
// - Trigger tally is 32-bit unsigned, counting external triggers.
// - First trigger after start reads one, then increments by one.
// - Tally wraps from maximum to zero and continues.
// - Every trigger counts while frame trigger is on, even those producing no acquisition.
// - With frame trigger off the tally is unavailable.
// - Power-off clears the tally to zero.
// - Tally clear source is software, line 1, line 2 or off.
// - Clear source defaults to off after reset.
// - With software source, the clear command clears the tally.
// - All line levels sampled at trigger and attached when enabled.
// - Line snapshot is a 32-bit word, one bit per line.
// - Snapshot bit is 0 for low line, 1 for high line.
module fmc_chunk_counters
(
	// Clocking.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Configuration from the host.
	input wire logic metadata_mode_on,
	input wire logic [1:0] metadata_kind_pick,
	input wire logic metadata_kind_on,
	input wire logic metadata_kind_wr,
	input wire logic count_unit_pick,
	input wire logic [1:0] count_unit_event_src,
	input wire logic config_wr,
	input wire logic [1:0] count_clear_src,
	input wire logic count_clear_src_wr,
	input wire logic count_clear_cmd,
	input wire logic frame_trigger_on,
	// Camera pins.
	input wire logic acquire_trigger_pin,
	input wire logic [1:0] in_line_pin,
	input wire logic [3:0] out_line_level,
	// Acquisition side, same clock domain.
	input wire logic acquire_busy,
	// Metadata for the frame.
	output logic frame_valid,
	output logic [63:0] frame_time_value,
	output logic frame_time_on,
	output logic [31:0] trigger_tally_value,
	output logic trigger_tally_on,
	output logic [31:0] line_levels_snapshot,
	output logic line_levels_on,
	// Live state.
	output logic [63:0] time_now,
	output logic [31:0] tally_now,
	output logic [1:0] clear_src_now
);

	typedef struct packed {
		logic [63:0] ts;
		logic [7:0] frac;
		logic [31:0] tally;
		logic [2:0] kind_en;
		fmc_pkg::fmc_clr_src_t clr_src;
		fmc_pkg::fmc_evt_src_t unit_evt;
		logic valid;
		logic [63:0] cap_ts;
		logic ts_on;
		logic [31:0] cap_tally;
		logic tally_on;
		logic [31:0] cap_lines;
		logic lines_on;
	} fmc_state_t;

	fmc_state_t st_r;
	fmc_state_t st_nxt;

	logic trig_q;
	logic trig_rise;
	logic [1:0] line_q;
	logic [1:0] line_rise;

	// The trigger and input line pins pass two flip-flops before anything reads them; out_line_level goes straight in.
	fmc_sync u_trig_sync
	(
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.d(acquire_trigger_pin),
		.q(trig_q),
		.rise(trig_rise)
	);

	fmc_sync u_line1_sync
	(
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.d(in_line_pin[0]),
		.q(line_q[0]),
		.rise(line_rise[0])
	);

	fmc_sync u_line2_sync
	(
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.d(in_line_pin[1]),
		.q(line_q[1]),
		.rise(line_rise[1])
	);

	logic trig_evt;
	logic tally_clr;
	logic [31:0] lines_word;
	logic [8:0] frac_sum;
	logic tally_ready;

	// A trigger only counts while the frame trigger is switched on.
	assign trig_evt = trig_rise & frame_trigger_on;

	// The tally only serves its chunk once the first unit watches triggers.
	assign tally_ready = (st_r.unit_evt == fmc_pkg::FMC_EVT_TRIGGER) & frame_trigger_on;

	// Clear request from whichever source is chosen; off never clears.
	always_comb
	begin
		case (st_r.clr_src)
			fmc_pkg::FMC_CLR_SOFT: tally_clr = count_clear_cmd;
			fmc_pkg::FMC_CLR_LINE1: tally_clr = line_rise[0];
			fmc_pkg::FMC_CLR_LINE2: tally_clr = line_rise[1];
			default: tally_clr = 1'b0;
		endcase
	end

	// Snapshot word: spare bits stay zero, each line bit mirrors its level.
	always_comb
	begin
		lines_word = '0;
		lines_word[fmc_pkg::IN_POS +: fmc_pkg::IN_LINES] = line_q;
		lines_word[fmc_pkg::OUT_POS +: fmc_pkg::OUT_LINES] = out_line_level;
	end

	assign frac_sum = {1'b0, st_r.frac} + {1'b0, fmc_pkg::TS_REM};

	// All next-state logic; nothing moves while ce is low.
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.valid = 1'b0;
		if (ce)
		begin
			// The clock period is several ticks; the leftover nanoseconds carry over.
			st_nxt.ts = st_r.ts + fmc_pkg::TS_INC;
			st_nxt.frac = frac_sum[7:0];
			if (frac_sum >= {1'b0, fmc_pkg::TS_TICK})
			begin
				st_nxt.frac = 8'(frac_sum - {1'b0, fmc_pkg::TS_TICK});
				st_nxt.ts = st_r.ts + fmc_pkg::TS_INC + 64'h1;
			end

			// Kind enables are written one at a time after picking the kind.
			if (metadata_kind_wr && metadata_kind_pick <= 2'(fmc_pkg::FMC_KIND_LINES))
				st_nxt.kind_en[metadata_kind_pick] = metadata_kind_on;
			if (config_wr && count_unit_pick == fmc_pkg::FMC_FIRST_UNIT)
				st_nxt.unit_evt = fmc_pkg::fmc_evt_src_t'(count_unit_event_src);
			if (count_clear_src_wr)
				st_nxt.clr_src = fmc_pkg::fmc_clr_src_t'(count_clear_src);

			// A trigger in the clearing cycle counts from zero, so it reads one.
			if (trig_evt)
			begin
				// Busy acquisition still counts the trigger, revealing overtrigger.
				st_nxt.tally = tally_clr ? fmc_pkg::TALLY_ONE : st_r.tally + 32'h1;
			end
			else if (tally_clr)
			begin
				st_nxt.tally = fmc_pkg::TALLY_RESET;
			end

			// Only an accepted trigger starts a frame and takes the snapshot.
			if (trig_evt && !acquire_busy)
			begin
				st_nxt.valid = 1'b1;
				st_nxt.cap_ts = st_r.ts;
				st_nxt.cap_tally = tally_clr ? fmc_pkg::TALLY_ONE : st_r.tally + 32'h1;
				st_nxt.cap_lines = lines_word;
				st_nxt.ts_on = metadata_mode_on & st_r.kind_en[fmc_pkg::FMC_KIND_TIME];
				st_nxt.tally_on = metadata_mode_on & st_r.kind_en[fmc_pkg::FMC_KIND_TALLY] & tally_ready;
				st_nxt.lines_on = metadata_mode_on & st_r.kind_en[fmc_pkg::FMC_KIND_LINES];
			end

			// Dropping mode also withdraws any enables already granted.
			if (!metadata_mode_on)
			begin
				st_nxt.ts_on = 1'b0;
				st_nxt.tally_on = 1'b0;
				st_nxt.lines_on = 1'b0;
			end
		end
		else
		begin
			st_nxt.valid = st_r.valid;
		end
	end

	// Reset restarts time and tally at zero and sets the clear source to off.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_r <= '0;
			st_r.ts <= fmc_pkg::TS_RESET;
			st_r.tally <= fmc_pkg::TALLY_RESET;
			st_r.clr_src <= fmc_pkg::FMC_CLR_OFF;
			st_r.unit_evt <= fmc_pkg::FMC_EVT_OFF;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Outputs come straight from the state register.
	assign frame_valid = st_r.valid;
	assign frame_time_value = st_r.cap_ts;
	assign frame_time_on = st_r.ts_on;
	assign trigger_tally_value = st_r.cap_tally;
	assign trigger_tally_on = st_r.tally_on;
	assign line_levels_snapshot = st_r.cap_lines;
	assign line_levels_on = st_r.lines_on;
	assign time_now = st_r.ts;
	assign tally_now = st_r.tally;
	assign clear_src_now = st_r.clr_src;

endmodule

// *** design/fmc_sync.sv ***
`timescale 1ns/10ps
// Two-flop synchroniser with rising-edge pulse, frozen while ce is low.
module fmc_sync
(
	// Clocking.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Asynchronous level in, synchronised level and rise out.
	input wire logic d,
	output logic q,
	output logic rise
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} fmc_sync_t;

	fmc_sync_t st_r;
	fmc_sync_t st_nxt;

	// Only s2 looks at s1; the edge is taken between s2 and s3.
	always_comb
	begin
		st_nxt = st_r;
		if (ce)
		begin
			st_nxt.s1 = d;
			st_nxt.s2 = st_r.s1;
			st_nxt.s3 = st_r.s2;
		end
	end

	// Synchronous reset, as everywhere in the block.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign q = st_r.s2;
	assign rise = st_r.s2 & ~st_r.s3;

endmodule

// *** inc/fmc_pkg.sv ***
package fmc_pkg;

	// Time stamp width and tick period.
	localparam int TS_W = 64;
	localparam int TS_TICK_NS = 8;
	// The system clock period in nanoseconds.
	localparam int CLK_PERIOD_NS = 100;
	// Whole ticks covered by one clock period, rounded down; never less than one.
	localparam int TS_INC_RAW = CLK_PERIOD_NS / TS_TICK_NS;
	localparam int TS_INC_INT = (TS_INC_RAW < 1) ? 1 : TS_INC_RAW;
	localparam logic [63:0] TS_INC = 64'(TS_INC_INT);
	// Remainder of the clock period, carried so the time stamp does not drift.
	localparam int TS_REM_INT = CLK_PERIOD_NS - TS_INC_INT * TS_TICK_NS;
	localparam logic [7:0] TS_REM = 8'(TS_REM_INT);
	localparam logic [7:0] TS_TICK = 8'(TS_TICK_NS);
	localparam logic [63:0] TS_RESET = 64'h0;

	// Trigger tally width and values.
	localparam int TALLY_W = 32;
	localparam logic [31:0] TALLY_RESET = 32'h0;
	localparam logic [31:0] TALLY_ONE = 32'h1;

	// Line snapshot layout: inputs in the low bits, outputs from bit 8.
	localparam int LINE_W = 32;
	localparam int IN_LINES = 2;
	localparam int OUT_LINES = 4;
	localparam int IN_POS = 0;
	localparam int OUT_POS = 8;

	// Metadata kinds chosen with the kind selector.
	typedef enum logic [1:0] {
		FMC_KIND_TIME,
		FMC_KIND_TALLY,
		FMC_KIND_LINES
	} fmc_kind_t;

	// Clear sources for the trigger tally.
	typedef enum logic [1:0] {
		FMC_CLR_OFF,
		FMC_CLR_SOFT,
		FMC_CLR_LINE1,
		FMC_CLR_LINE2
	} fmc_clr_src_t;

	// Event sources for the selected count unit.
	typedef enum logic [1:0] {
		FMC_EVT_OFF,
		FMC_EVT_TRIGGER,
		FMC_EVT_FRAME
	} fmc_evt_src_t;

	localparam logic [0:0] FMC_FIRST_UNIT = 1'h0;

endpackage
